/* File: dv/spi_peer_model.sv */
`timescale 1ns/1ns
`default_nettype none
module spi_peer_model
(
	input  wire logic i_sclk,
	input  wire logic i_mosi,
	input  wire logic i_sel_n,
	output logic      o_miso
);
	logic [7:0] tx_q;
	logic [7:0] rx_q;
	logic [7:0] send_q[$];
	logic [7:0] got_q[$];
	int         cnt;
	initial o_miso = 1'b0;
	// mode 0: msb is on the line as soon as we are selected
	always @(negedge i_sel_n)
	begin
		tx_q = (send_q.size() > 0) ? send_q.pop_front() : 8'h00;
		cnt = 0;
		o_miso = tx_q[7];
	end
	// released line: inverse of last bit so a stale value never passes
	always @(posedge i_sel_n) o_miso = ~o_miso;
	always @(posedge i_sclk)
	begin
		if (!i_sel_n && cnt < 8)
		begin
			rx_q = {rx_q[6:0], i_mosi};
			cnt++;
			if (cnt == 8) got_q.push_back(rx_q);
		end
	end
	always @(negedge i_sclk) if (!i_sel_n && cnt < 8) o_miso = tx_q[3'(7 - cnt)];
endmodule // spi_peer_model
`default_nettype wire

/* File: dv/tb_spi_status_and_data_buffers.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_spi_status_and_data_buffers;
	import spi_buf_pkg::*;
	logic        i_clk;
	logic        i_resetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hready;
	logic        hresp;
	logic        sclk, sclk_oe, mosi, mosi_oe, miso, miso_oe, peer_miso;
	logic        ss_n, ss_n_oe, ss_drv, irq;
	logic        tb_sclk, tb_mosi;
	logic [31:0] rd;
	int          bad_count = 0;
	int          samples_checked = 0;
	int          cycles = 0;

	spi_status_and_data_buffers spi_status_and_data_buffers_inst
	(
		.i_clk(i_clk), .i_resetn(i_resetn), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
		.i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
		.i_sclk(sclk_oe ? sclk : tb_sclk), .o_sclk(sclk), .o_sclk_oe(sclk_oe),
		.i_mosi(mosi_oe ? mosi : tb_mosi), .o_mosi(mosi), .o_mosi_oe(mosi_oe),
		.i_miso(miso_oe ? miso : peer_miso), .o_miso(miso), .o_miso_oe(miso_oe),
		.i_ss_n(ss_n_oe ? ss_n : ss_drv), .o_ss_n(ss_n), .o_ss_n_oe(ss_n_oe), .o_irq(irq)
	);

	spi_peer_model spi_peer_model_inst
	(
		.i_sclk(sclk_oe ? sclk : 1'b0), .i_mosi(mosi_oe ? mosi : 1'b0),
		.i_sel_n(ss_n_oe ? ss_n : ss_drv), .o_miso(peer_miso)
	);

	initial
	begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end

	always @(posedge i_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			bad_count++;
			results();
		end
	end

	task results();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		samples_checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD %0t %s: got %h want %h", $time, what, seen, exp);
		end
	endtask

	// entered just after a rising edge; holds each phase until hready is seen
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= wr;
		do @(posedge i_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge i_clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic st(input logic [31:0] exp, input logic [31:0] m, input string what);
		bus(1'b0, OFS_STATUS, 32'h0);
		check(rd & m, exp, what);
	endtask

	// polling also arms the clear sequences, which later steps rely on
	task automatic poll_rxf();
		int n = 0;
		bus(1'b0, OFS_STATUS, 32'h0);
		while (rd[ST_RXF_BIT] !== 1'b1 && n < 300)
		begin
			bus(1'b0, OFS_STATUS, 32'h0);
			n++;
		end
	endtask

	// external master in mode 0: data set before the rising edge, changed on falling
	task automatic slave_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--)
		begin
			tb_mosi <= b[i];
			repeat (4) @(posedge i_clk);
			tb_sclk <= 1'b1;
			repeat (4) @(posedge i_clk);
			tb_sclk <= 1'b0;
		end
	endtask

	task automatic wait_ss(input logic lvl);
		int n = 0;
		while (ss_n !== lvl && n < 300)
		begin
			@(posedge i_clk);
			n++;
		end
	endtask

	initial
	begin
		i_resetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		ss_drv = 1'b1;
		tb_sclk = 1'b0;
		tb_mosi = 1'b0;
		repeat (20) @(posedge i_clk);
		i_resetn <= 1'b1;
		@(posedge i_clk);
		bus(1'b1, OFS_CTRL2, 32'h10);
		bus(1'b1, OFS_CTRL1, 32'h52);
		bus(1'b1, OFS_DATA, 32'hee);
		repeat (20) @(posedge i_clk);
		check({31'h0, ss_n}, 32'h1, "unarmed write started");
		bus(1'b0, OFS_DATA, 32'h0);
		check(rd, 32'h0, "rx buffer after reset");
		st(32'h20, '1, "status after reset");
		bus(1'b1, OFS_STATUS, 32'hff);
		bus(1'b0, 32'h10, 32'h0);
		check(rd, 32'h0, "unmapped read");
		st(32'h20, '1, "status write");
		$display("test reset done");
		spi_peer_model_inst.send_q = '{8'h3c, 8'hc3, 8'h77};
		bus(1'b1, OFS_DATA, 32'ha5);
		// the flag returns one cycle after the write lands; leave room for it
		repeat (2) @(posedge i_clk);
		st(32'h20, '1, "idle move");
		wait_ss(1'b0);
		check({31'h0, ss_n}, 32'h0, "master start");
		bus(1'b1, OFS_DATA, 32'h5a);
		st(32'h00, '1, "queued byte");
		poll_rxf();
		check(rd & 32'h80, 32'h80, "first done");
		repeat (2) @(posedge i_clk);
		st(32'ha0, '1, "reload");
		bus(1'b0, OFS_DATA, 32'h0);
		check(rd, 32'h3c, "rx byte");
		st(32'h20, '1, "rx cleared");
		poll_rxf();
		bus(1'b1, OFS_DATA, 32'h11);
		wait_ss(1'b0);
		wait_ss(1'b1);
		repeat (20) @(posedge i_clk);
		check({31'h0, ss_n}, 32'h1, "no reload");
		st(32'ha0, '1, "txe stays");
		bus(1'b0, OFS_DATA, 32'h0);
		check(rd, 32'hc3, "overrun keeps old");
		check(32'(spi_peer_model_inst.got_q.size()), 32'h3, "byte count");
		check({8'h0, spi_peer_model_inst.got_q[0], spi_peer_model_inst.got_q[1],
			spi_peer_model_inst.got_q[2]}, 32'ha55a11, "mosi bytes");
		$display("test transfers done");
		bus(1'b1, OFS_CTRL1, 32'h72);
		@(posedge i_clk);
		check({31'h0, irq}, 32'h1, "tx irq");
		bus(1'b1, OFS_CTRL1, 32'h52);
		@(posedge i_clk);
		check({31'h0, irq}, 32'h0, "irq masked");
		$display("test irq done");
		bus(1'b1, OFS_CTRL2, 32'h0);
		bus(1'b1, OFS_CTRL1, 32'h50);
		ss_drv <= 1'b0;
		repeat (10) @(posedge i_clk);
		st(32'h0, 32'h10, "fault gated");
		bus(1'b1, OFS_CTRL2, 32'h10);
		repeat (10) @(posedge i_clk);
		bus(1'b1, OFS_CTRL1, 32'hd0);
		@(posedge i_clk);
		check({31'h0, irq}, 32'h1, "fault irq");
		st(32'h10, 32'h10, "fault set");
		ss_drv <= 1'b1;
		repeat (5) @(posedge i_clk);
		bus(1'b1, OFS_CTRL1, 32'h50);
		st(32'h0, 32'h10, "fault cleared");
		$display("test fault done");
		bus(1'b1, OFS_CTRL1, 32'h40);
		ss_drv <= 1'b0;
		repeat (4) @(posedge i_clk);
		slave_byte(8'h96);
		repeat (6) @(posedge i_clk);
		ss_drv <= 1'b1;
		st(32'h80, 32'h80, "slave rx full");
		bus(1'b0, OFS_DATA, 32'h0);
		check(rd, 32'h96, "slave rx byte");
		$display("test slave done");
		results();
	end
endmodule // tb_spi_status_and_data_buffers
`default_nettype wire

/* File: hw/spi_buf_pkg.sv */
package spi_buf_pkg;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned BYTE_W = 8;
	// register byte addresses
	localparam logic [31:0] OFS_CTRL1  = 32'h0000_0000;
	localparam logic [31:0] OFS_CTRL2  = 32'h0000_0004;
	localparam logic [31:0] OFS_STATUS = 32'h0000_0008;
	localparam logic [31:0] OFS_DATA   = 32'h0000_000c;
	// status fields
	localparam int unsigned ST_RXF_BIT  = 7;
	localparam int unsigned ST_TXE_BIT  = 5;
	localparam int unsigned ST_MODE_FAULT_FLAG_BIT = 4;
	// control one fields
	localparam int unsigned C1_RXIE_BIT = 7;
	localparam int unsigned C1_EN_BIT   = 6;
	localparam int unsigned C1_TXIE_BIT = 5;
	localparam int unsigned C1_MASTER_SELECT_BIT = 4;
	localparam int unsigned C1_SELECT_OUTPUT_ENABLE_BIT = 1;
	localparam logic [7:0]  C1_WMASK    = 8'hf2;
	localparam logic [7:0]  C1_RST      = 8'h00;
	// control two fields
	localparam int unsigned C2_FEN_BIT  = 4;
	localparam logic [7:0]  C2_WMASK    = 8'h10;
	localparam logic [7:0]  C2_RST      = 8'h00;
	// ahb-lite
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic        HRESP_OKAY    = 1'h0;
	// serial timing
	localparam int unsigned CLK_NS        = 100;
	localparam int unsigned SCLK_HALF_NS  = 400;
	localparam int unsigned HALF_CYC      = SCLK_HALF_NS / CLK_NS;
	localparam logic [2:0]  HALF_LAST     = 3'(HALF_CYC - 1);
	localparam logic [3:0]  LAST_BIT      = 4'h7;
	// idle pin levels: sclk low in mode 0, select high, so no false edge follows reset
	localparam logic [3:0]  SYNC_RST      = 4'h1;
	typedef enum logic [1:0] {
		XS_IDLE  = 2'h0,
		XS_SHIFT = 2'h1,
		XS_DONE  = 2'h3
	} xfer_state_t;
endpackage

/* File: hw/spi_status_and_data_buffers.sv */
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module spi_status_and_data_buffers
	import spi_buf_pkg::*;
(
	input  wire logic                           i_clk,
	input  wire logic                           i_resetn,
	input  wire logic                           i_hsel,
	input  wire logic [spi_buf_pkg::DATA_W-1:0] i_haddr,
	input  wire logic [1:0]                     i_htrans,
	input  wire logic                           i_hwrite,
	input  wire logic [2:0]                     i_hsize,
	input  wire logic [spi_buf_pkg::DATA_W-1:0] i_hwdata,
	input  wire logic                           i_hready,
	output logic      [spi_buf_pkg::DATA_W-1:0] o_hrdata,
	output logic                                o_hreadyout,
	output logic                                o_hresp,
	input  wire logic                           i_sclk,
	output logic                                o_sclk,
	output logic                                o_sclk_oe,
	input  wire logic                           i_mosi,
	output logic                                o_mosi,
	output logic                                o_mosi_oe,
	input  wire logic                           i_miso,
	output logic                                o_miso,
	output logic                                o_miso_oe,
	input  wire logic                           i_ss_n,
	output logic                                o_ss_n,
	output logic                                o_ss_n_oe,
	output logic                                o_irq
);
	import spi_buf_pkg::*;

	function automatic logic hit(input logic [DATA_W-1:0] addr, input logic [DATA_W-1:0] ofs);
		hit = (addr == ofs);
	endfunction

	// pin synchronisers: order sclk, mosi, miso, ss_n
	logic [3:0] sync1_q;
	logic [3:0] sync2_q;
	logic       sclk3_q;

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			sync1_q <= SYNC_RST;
			sync2_q <= SYNC_RST;
			sclk3_q <= 1'b0;
		end
		else
		begin
			sync1_q <= {i_sclk, i_mosi, i_miso, i_ss_n};
			sync2_q <= sync1_q;
			sclk3_q <= sync2_q[3];
		end
	end

	logic sclk_s;
	logic mosi_s;
	logic miso_s;
	logic ss_n_s;
	assign sclk_s = sync2_q[3];
	assign mosi_s = sync2_q[2];
	assign miso_s = sync2_q[1];
	assign ss_n_s = sync2_q[0];

	// bus side state
	logic [DATA_W-1:0] hrdata_q;
	logic [DATA_W-1:0] hrdata_d;
	logic              dp_valid_q;
	logic              dp_valid_d;
	logic              dp_write_q;
	logic              dp_write_d;
	logic [DATA_W-1:0] dp_addr_q;
	logic [DATA_W-1:0] dp_addr_d;
	logic [7:0]        ctrl1_q;
	logic [7:0]        ctrl1_d;
	logic [7:0]        ctrl2_q;
	logic [7:0]        ctrl2_d;
	// flags, arming and buffers
	logic              rx_full_q;
	logic              rx_full_d;
	logic              tx_empty_q;
	logic              tx_empty_d;
	logic              mode_fault_q;
	logic              mode_fault_d;
	logic              rx_arm_q;
	logic              rx_arm_d;
	logic              tx_arm_q;
	logic              tx_arm_d;
	logic              mf_arm_q;
	logic              mf_arm_d;
	logic [7:0]        rx_buf_q;
	logic [7:0]        rx_buf_d;
	logic [7:0]        tx_buf_q;
	logic [7:0]        tx_buf_d;
	// shifter
	xfer_state_t       xs_q;
	xfer_state_t       xs_d;
	logic [7:0]        shift_q;
	logic [7:0]        shift_d;
	logic              shift_full_q;
	logic              shift_full_d;
	logic              sample_q;
	logic              sample_d;
	logic [3:0]        bit_cnt_q;
	logic [3:0]        bit_cnt_d;
	logic [2:0]        half_cnt_q;
	logic [2:0]        half_cnt_d;
	logic              sclk_q;
	logic              sclk_d;

	logic addr_ok;
	logic rd_status;
	logic rd_data;
	logic wr_any;
	logic wr_data;
	logic wr_ctrl1;
	logic wr_ctrl2;
	logic rx_clear;
	logic enabled;
	logic master;
	logic fault_cond;
	logic [7:0] status_byte;

	assign addr_ok   = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ);
	assign rd_status = addr_ok && !i_hwrite && hit(i_haddr, OFS_STATUS);
	assign rd_data   = addr_ok && !i_hwrite && hit(i_haddr, OFS_DATA);
	assign wr_any    = dp_valid_q && dp_write_q;
	assign wr_data   = wr_any && hit(dp_addr_q, OFS_DATA);
	assign wr_ctrl1  = wr_any && hit(dp_addr_q, OFS_CTRL1);
	assign wr_ctrl2  = wr_any && hit(dp_addr_q, OFS_CTRL2);
	assign rx_clear  = rd_data && rx_arm_q;
	assign enabled   = ctrl1_q[C1_EN_BIT];
	assign master    = enabled && ctrl1_q[C1_MASTER_SELECT_BIT];
	// select pin is a fault input only in this one setting
	assign fault_cond = master && ctrl2_q[C2_FEN_BIT] && !ctrl1_q[C1_SELECT_OUTPUT_ENABLE_BIT] && !ss_n_s;

	always_comb
	begin
		status_byte = 8'h00;
		status_byte[ST_RXF_BIT]  = rx_full_q;
		status_byte[ST_TXE_BIT]  = tx_empty_q;
		status_byte[ST_MODE_FAULT_FLAG_BIT] = mode_fault_q;
	end

	// bus group: address phase captures read data so hrdata comes from a flop
	always_comb
	begin
		hrdata_d   = hrdata_q;
		dp_valid_d = addr_ok;
		dp_write_d = addr_ok && i_hwrite;
		dp_addr_d  = addr_ok ? i_haddr : dp_addr_q;
		ctrl1_d    = ctrl1_q;
		ctrl2_d    = ctrl2_q;
		if (addr_ok && !i_hwrite)
		begin
			if (hit(i_haddr, OFS_CTRL1))
				hrdata_d = {24'h00_0000, ctrl1_q};
			else if (hit(i_haddr, OFS_CTRL2))
				hrdata_d = {24'h00_0000, ctrl2_q};
			else if (hit(i_haddr, OFS_STATUS))
				hrdata_d = {24'h00_0000, status_byte};
			else if (hit(i_haddr, OFS_DATA))
				hrdata_d = {24'h00_0000, rx_buf_q};
			else
				hrdata_d = 32'h0000_0000;
		end
		// status writes fall through untouched
		if (wr_ctrl1)
			ctrl1_d = i_hwdata[7:0] & C1_WMASK;
		if (wr_ctrl2)
			ctrl2_d = i_hwdata[7:0] & C2_WMASK;
	end

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			hrdata_q   <= 32'h0000_0000;
			dp_valid_q <= 1'b0;
			dp_write_q <= 1'b0;
			dp_addr_q  <= 32'h0000_0000;
			ctrl1_q    <= C1_RST;
			ctrl2_q    <= C2_RST;
		end
		else
		begin
			hrdata_q   <= hrdata_d;
			dp_valid_q <= dp_valid_d;
			dp_write_q <= dp_write_d;
			dp_addr_q  <= dp_addr_d;
			ctrl1_q    <= ctrl1_d;
			ctrl2_q    <= ctrl2_d;
		end
	end

	// core group: flag clears are applied first so a flag set in the same cycle wins; disarming by writes comes after arming, so it wins
	always_comb
	begin
		rx_full_d    = rx_full_q;
		tx_empty_d   = tx_empty_q;
		mode_fault_d = mode_fault_q;
		rx_arm_d     = rx_arm_q;
		tx_arm_d     = tx_arm_q;
		mf_arm_d     = mf_arm_q;
		rx_buf_d     = rx_buf_q;
		tx_buf_d     = tx_buf_q;
		xs_d         = xs_q;
		shift_d      = shift_q;
		shift_full_d = shift_full_q;
		sample_d     = sample_q;
		bit_cnt_d    = bit_cnt_q;
		half_cnt_d   = half_cnt_q;
		sclk_d       = sclk_q;
		// arming by status reads
		if (rd_status && rx_full_q)
			rx_arm_d = 1'b1;
		if (rd_status && tx_empty_q)
			tx_arm_d = 1'b1;
		if (rd_status && mode_fault_q)
			mf_arm_d = 1'b1;
		if (rd_data)
			rx_arm_d = 1'b0;
		if (rx_clear)
			rx_full_d = 1'b0;
		if (wr_data)
		begin
			tx_arm_d = 1'b0;
			if (tx_arm_q)
			begin
				tx_buf_d   = i_hwdata[7:0];
				tx_empty_d = 1'b0;
			end
		end
		if (wr_ctrl1)
		begin
			mf_arm_d = 1'b0;
			if (mf_arm_q)
				mode_fault_d = 1'b0;
		end
		unique case (xs_q)
			XS_IDLE:
			begin
				sclk_d     = 1'b0;
				half_cnt_d = 3'h0;
				bit_cnt_d  = 4'h0;
				if (!tx_empty_q && !shift_full_q)
				begin
					shift_d      = tx_buf_q;
					shift_full_d = 1'b1;
					tx_empty_d   = 1'b1;
				end
				else if (shift_full_q && master && !fault_cond)
				begin
					shift_full_d = 1'b0;
					xs_d         = XS_SHIFT;
				end
				else if (enabled && !master && !ss_n_s)
				begin
					shift_full_d = 1'b0;
					xs_d         = XS_SHIFT;
				end
			end
			XS_SHIFT:
			begin
				if (master)
				begin
					half_cnt_d = half_cnt_q + 3'h1;
					if (half_cnt_q == HALF_LAST)
					begin
						half_cnt_d = 3'h0;
						sclk_d     = !sclk_q;
						if (!sclk_q)
							sample_d = miso_s;
						else
						begin
							shift_d   = {shift_q[6:0], sample_q};
							bit_cnt_d = bit_cnt_q + 4'h1;
							if (bit_cnt_q == LAST_BIT)
								xs_d = XS_DONE;
						end
					end
				end
				else if (ss_n_s || !enabled)
					xs_d = XS_IDLE; // deselected mid-byte: partial byte dropped
				else if (sclk_s && !sclk3_q)
					sample_d = mosi_s;
				else if (!sclk_s && sclk3_q)
				begin
					shift_d   = {shift_q[6:0], sample_q};
					bit_cnt_d = bit_cnt_q + 4'h1;
					if (bit_cnt_q == LAST_BIT)
						xs_d = XS_DONE;
				end
			end
			XS_DONE:
			begin
				xs_d = XS_IDLE;
				// overrun drops the new byte silently
				if (!rx_full_q || rx_clear)
				begin
					rx_buf_d  = shift_q;
					rx_full_d = 1'b1;
				end
			end
			default:
				xs_d = XS_IDLE;
		endcase
		if (fault_cond)
		begin
			mode_fault_d = 1'b1;
			if (xs_q == XS_SHIFT)
				xs_d = XS_IDLE;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			rx_full_q    <= 1'b0;
			tx_empty_q   <= 1'b1;
			mode_fault_q <= 1'b0;
			rx_arm_q     <= 1'b0;
			tx_arm_q     <= 1'b0;
			mf_arm_q     <= 1'b0;
			rx_buf_q     <= 8'h00;
			tx_buf_q     <= 8'h00;
			xs_q         <= XS_IDLE;
			shift_q      <= 8'h00;
			shift_full_q <= 1'b0;
			sample_q     <= 1'b0;
			bit_cnt_q    <= 4'h0;
			half_cnt_q   <= 3'h0;
			sclk_q       <= 1'b0;
		end
		else
		begin
			rx_full_q    <= rx_full_d;
			tx_empty_q   <= tx_empty_d;
			mode_fault_q <= mode_fault_d;
			rx_arm_q     <= rx_arm_d;
			tx_arm_q     <= tx_arm_d;
			mf_arm_q     <= mf_arm_d;
			rx_buf_q     <= rx_buf_d;
			tx_buf_q     <= tx_buf_d;
			xs_q         <= xs_d;
			shift_q      <= shift_d;
			shift_full_q <= shift_full_d;
			sample_q     <= sample_d;
			bit_cnt_q    <= bit_cnt_d;
			half_cnt_q   <= half_cnt_d;
			sclk_q       <= sclk_d;
		end
	end

	assign o_hrdata    = hrdata_q;
	assign o_hreadyout = 1'b1;
	assign o_hresp     = HRESP_OKAY;
	assign o_sclk      = sclk_q;
	assign o_sclk_oe   = master;
	assign o_mosi      = shift_q[7];
	assign o_mosi_oe   = master;
	assign o_miso      = shift_q[7];
	assign o_miso_oe   = enabled && !master && !ss_n_s;
	assign o_ss_n      = (xs_q == XS_IDLE);
	assign o_ss_n_oe   = master && ctrl2_q[C2_FEN_BIT] && ctrl1_q[C1_SELECT_OUTPUT_ENABLE_BIT];
	assign o_irq       = (tx_empty_q && ctrl1_q[C1_TXIE_BIT]) ||
		((rx_full_q || mode_fault_q) && ctrl1_q[C1_RXIE_BIT]);

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_resetn);

	sequence s_idle_accept;
		wr_data && tx_arm_q && (xs_q == XS_IDLE) && !shift_full_q && tx_empty_q;
	endsequence

	sequence s_done_unread;
		(xs_q == XS_DONE) && rx_full_q && !rx_clear;
	endsequence

	AST_RXF_SET: assert property ((xs_q == XS_DONE) |=> rx_full_q)
		else $error("receive-full not set after transfer end");
	AST_RXF_CLEAR: assert property ($fell(rx_full_q) |-> $past(rx_clear))
		else $error("receive-full cleared without armed data read");
	AST_TXE_WRITE: assert property (s_idle_accept |=> !tx_empty_q ##1 tx_empty_q)
		else $error("accepted write did not clear then reload transmit-empty");
	AST_TX_DISCARD: assert property (wr_data && !tx_arm_q |=> $stable(tx_buf_q))
		else $error("unarmed data write changed transmit buffer");
	AST_TX_IRQ: assert property (tx_empty_q && ctrl1_q[C1_TXIE_BIT] |-> o_irq)
		else $error("transmit interrupt missing");
	AST_IDLE_MOVE: assert property (s_idle_accept |-> ##[1:2] (tx_empty_q && shift_full_q))
		else $error("idle move took more than two cycles");
	AST_MODE_FAULT_FLAG_GATE: assert property ($rose(mode_fault_q) |-> $past(fault_cond))
		else $error("mode fault set outside fault setting");
	AST_OVERRUN: assert property (s_done_unread |=> $stable(rx_buf_q) && rx_full_q)
		else $error("overrun replaced unread receive byte");
	AST_STATUS_ZERO: assert property (rd_status |=> (o_hrdata[6] == 1'b0) && (o_hrdata[3:0] == 4'h0))
		else $error("reserved status bits not zero");
	AST_FAULT_IRQ: assert property ((rx_full_q || mode_fault_q) && ctrl1_q[C1_RXIE_BIT] |-> o_irq)
		else $error("receive or fault interrupt missing");

endmodule // spi_status_and_data_buffers
`default_nettype wire
